// >>> cuc_card_unit.sv
// Card unit cycle sequencer with stop and fault handling, Avalon-MM registers.
// Assumes host strobes, panel controls and sensors are synchronous to i_clk_sys.
//
// Summary of operation
// - Start-only cycles advance cards until the last ones reach their stackers.
// - Short start press runs one cycle; holding start keeps cycling.
// - Pick switches with start held feed a card into that channel each cycle.
// - Standby or held stop button halts at cycle end; release resumes.
// - Clear with start drives the channel and bypasses the empty-hopper stop.
// - A host B stop lets the current card cycle finish before halting.
// - Overheat raises a host A stop and its lamp without stopping the cards.
// - Missing or late transfers raise a B stop and the no-information lamp.
// - Read due with no card in the reading station raises a B stop and lamp.
// - Punch due with no card under the die raises a B stop and lamp.
// - Loss of drive motor power lights the supply fault lamp.
// - Punch jam stops at once, drops voltages and lights the jam lamp.
// - Stacker full, hopper empty, stop, standby or jam stop and light stop lamp.
// - Every stop but a jam resumes without losing data.
// - Either empty hopper stops the unit, even the one not in use.
`timescale 1ns/1ps
`default_nettype none
module cuc_card_unit #(
  parameter int unsigned P_CARD_CYC = cuc_pkg::CARD_CYC,
  parameter int unsigned P_FIRST_WIN_CYC = cuc_pkg::FIRST_WIN_CYC,
  parameter int unsigned P_ROW_PER_CYC = cuc_pkg::ROW_PER_CYC,
  parameter int unsigned P_ROW_DL_CYC = cuc_pkg::ROW_DL_CYC
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Avalon-MM slave
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_irq,
  // Host instructions and stops
  input wire cuc_pkg::cuc_host_req_t i_host,
  input wire logic i_host_ack,
  output logic [35:0] o_in_data,
  output logic o_stop_a,
  output logic o_stop_b,
  // Operator panel and mechanism
  input wire cuc_pkg::cuc_panel_t i_panel,
  input wire cuc_pkg::cuc_mech_t i_mech,
  output cuc_pkg::cuc_lamp_t o_lamp,
  output logic o_drive,
  output logic o_volt_en,
  output logic o_pick_read,
  output logic o_pick_punch,
  output logic [35:0] o_punch_data,
  output logic o_punch_stb
);
  cuc_pkg::cuc_state_t state_r;
  cuc_pkg::cuc_fsel_t fsel_r, cur_r;
  logic [31:0] cyc_r, row_tmr_r;
  logic [3:0] row_idx_r;
  logic [1:0] ow_r, ir_r;
  logic row_act_r, host_pend_r, man_pend_r, start_d_r, b_halt_r, oh_d_r;
  logic [1:0] ctrl_r;
  logic [4:0] irq_st_r, irq_msk_r;
  logic [31:0] rdata_nxt;
  logic [4:0] irq_ev, irq_clr;
  logic cyc_end, go, cyc_start, stop_cond, hop_stop, b_ev, noinfo_ev, nord_ev, nopn_ev;
  logic op_restart, wr_do, xfer_on, start_edge;
  logic [1:0] need_w, need_r;

  // Clear with start bypasses the empty-hopper stop; either hopper counts
  assign hop_stop = (i_mech.rd_hop_empty | i_mech.pn_hop_empty) & ~(i_panel.clear & i_panel.start);
  assign stop_cond = hop_stop | i_mech.rd_stk_full | i_mech.wr_stk_full | i_panel.stop_btn
                     | i_panel.standby | ctrl_r[cuc_pkg::CTRL_STANDBY_BIT] | i_mech.jam;
  assign cyc_end = (state_r == cuc_pkg::ST_RUN) && (cyc_r == 32'(P_CARD_CYC - 1));
  assign start_edge = i_panel.start & ~start_d_r;
  assign op_restart = start_edge && (state_r == cuc_pkg::ST_IDLE);
  // A new cycle only begins at a cycle boundary, so stops other than a jam act at cycle end
  assign go = ~stop_cond & ~b_halt_r & (host_pend_r | man_pend_r | i_panel.start);
  assign cyc_start = go && !i_mech.jam && ((state_r == cuc_pkg::ST_IDLE) || cyc_end);
  assign nord_ev = cyc_start && host_pend_r && fsel_r.read && !i_mech.rd_card;
  assign nopn_ev = cyc_start && host_pend_r && fsel_r.punch && !i_mech.pn_card;
  assign xfer_on = cur_r.read | cur_r.punch;
  assign need_w = cur_r.punch ? cuc_pkg::GRP_XFERS : 2'h0;
  assign need_r = cur_r.read ? cuc_pkg::GRP_XFERS : 2'h0;
  assign noinfo_ev = (state_r == cuc_pkg::ST_RUN) && xfer_on && row_act_r &&
                     (((row_tmr_r == 32'(P_ROW_DL_CYC - 1)) && (ow_r == 2'h0) && (ir_r == 2'h0)) ||
                      ((row_tmr_r == 32'(P_ROW_PER_CYC - 1)) && ((ow_r < need_w) || (ir_r < need_r))));
  assign b_ev = noinfo_ev | nord_ev | nopn_ev;

  // Card cycle sequencer
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_r <= cuc_pkg::ST_IDLE;
      cyc_r <= 32'h0;
      cur_r <= '0;
      o_drive <= 1'b0;
      o_volt_en <= 1'b1;
      o_pick_read <= 1'b0;
      o_pick_punch <= 1'b0;
    end else begin
      case (state_r)
        cuc_pkg::ST_IDLE, cuc_pkg::ST_RUN: begin
          if (i_mech.jam) begin
            // Jam is not resumable: only a reset leaves this state
            state_r <= cuc_pkg::ST_JAM;
            o_drive <= 1'b0;
            o_volt_en <= 1'b0;
            o_pick_read <= 1'b0;
            o_pick_punch <= 1'b0;
          end else if (cyc_start) begin
            state_r <= cuc_pkg::ST_RUN;
            cyc_r <= 32'h0;
            o_drive <= 1'b1;
            if (host_pend_r) begin
              cur_r <= fsel_r;
              o_pick_read <= fsel_r.pick_read;
              o_pick_punch <= fsel_r.pick_punch;
            end else begin
              cur_r <= '{start: 1'b1, pick_read: i_panel.pick_read, pick_punch: i_panel.pick_punch, default: 1'b0};
              o_pick_read <= i_panel.pick_read;
              o_pick_punch <= i_panel.pick_punch;
            end
          end else if (cyc_end) begin
            state_r <= cuc_pkg::ST_IDLE;
            o_drive <= 1'b0;
            o_pick_read <= 1'b0;
            o_pick_punch <= 1'b0;
            cur_r <= '0;
          end else if (state_r == cuc_pkg::ST_RUN) begin
            cyc_r <= cyc_r + 32'h1;
          end
        end
        cuc_pkg::ST_JAM: begin
          o_drive <= 1'b0;
          o_volt_en <= 1'b0;
        end
        default: state_r <= cuc_pkg::ST_IDLE;
      endcase
    end
  end

  // Pending host selection and manual start
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      fsel_r <= '0;
      host_pend_r <= 1'b0;
      man_pend_r <= 1'b0;
      start_d_r <= 1'b0;
    end else begin
      start_d_r <= i_panel.start;
      if (i_host.fsel_v && ctrl_r[cuc_pkg::CTRL_HOST_EN_BIT]) begin
        fsel_r <= i_host.fsel;
        host_pend_r <= i_host.fsel.start;
      end else if (cyc_start && !(fsel_r.free_run && !fsel_r.stop)) begin
        host_pend_r <= 1'b0;
      end
      // A short press is remembered so that it runs exactly one cycle;
      // a press that itself starts the cycle is used up at once
      if (start_edge && !cyc_start) begin
        man_pend_r <= 1'b1;
      end else if (cyc_start) begin
        man_pend_r <= 1'b0;
      end
    end
  end

  // Row points and transfer accounting
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      row_act_r <= 1'b0;
      row_tmr_r <= 32'h0;
      row_idx_r <= 4'h0;
      ow_r <= 2'h0;
      ir_r <= 2'h0;
    end else if (cyc_start) begin
      row_act_r <= 1'b0;
      row_idx_r <= 4'h0;
      row_tmr_r <= 32'h0;
      ow_r <= 2'h0;
      ir_r <= 2'h0;
    end else if (state_r == cuc_pkg::ST_RUN) begin
      if (i_host.out_v && ow_r != cuc_pkg::GRP_XFERS) begin
        ow_r <= ow_r + 2'h1;
      end
      if (i_host.in_v && ir_r != cuc_pkg::GRP_XFERS) begin
        ir_r <= ir_r + 2'h1;
      end
      // First row point sits 1.5 ms before the 140.5 ms window closes
      if (!row_act_r && row_idx_r == 4'h0 && cyc_r == 32'(P_FIRST_WIN_CYC - P_ROW_DL_CYC - 1)) begin
        row_act_r <= 1'b1;
      end else if (row_act_r) begin
        if (row_tmr_r == 32'(P_ROW_PER_CYC - 1)) begin
          row_tmr_r <= 32'h0;
          ow_r <= {1'b0, i_host.out_v};
          ir_r <= {1'b0, i_host.in_v};
          if (row_idx_r == cuc_pkg::ROWS - 4'h1) begin
            row_act_r <= 1'b0;
          end else begin
            row_idx_r <= row_idx_r + 4'h1;
          end
        end else begin
          row_tmr_r <= row_tmr_r + 32'h1;
        end
      end
    end
  end

  // Data paths of the transfers
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_punch_data <= 36'h0;
      o_punch_stb <= 1'b0;
      o_in_data <= 36'h0;
    end else begin
      o_punch_stb <= i_host.out_v && (state_r == cuc_pkg::ST_RUN) && cur_r.punch;
      if (i_host.out_v) begin
        o_punch_data <= i_host.out_data;
      end
      if (i_host.in_v) begin
        o_in_data <= i_mech.sense;
      end
    end
  end

  // Faults, lamps and host stops; a new event wins over a clear
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_lamp <= '0;
      o_stop_a <= 1'b0;
      o_stop_b <= 1'b0;
      b_halt_r <= 1'b0;
      oh_d_r <= 1'b0;
    end else begin
      oh_d_r <= i_mech.overheat;
      o_lamp.stop <= stop_cond;
      o_lamp.overheat <= i_mech.overheat;
      o_lamp.supply_loss_fault <= ~i_mech.motor_ok;
      o_lamp.jam <= o_lamp.jam | i_mech.jam;
      o_lamp.no_info <= noinfo_ev | (o_lamp.no_info & ~op_restart);
      o_lamp.no_rd_card <= nord_ev | (o_lamp.no_rd_card & ~op_restart);
      o_lamp.no_pn_card <= nopn_ev | (o_lamp.no_pn_card & ~op_restart);
      b_halt_r <= b_ev | (b_halt_r & ~op_restart);
      o_stop_b <= b_ev | (o_stop_b & ~i_host_ack);
      o_stop_a <= (i_mech.overheat & ~oh_d_r) | (o_stop_a & ~i_host_ack);
    end
  end

  // Avalon-MM slave: one wait cycle, then the access completes
  assign wr_do = i_avs_write && !o_avs_waitrequest;
  always_comb begin
    rdata_nxt = 32'h0;
    case (i_avs_address)
      cuc_pkg::REG_CTRL: rdata_nxt = {30'h0, ctrl_r};
      cuc_pkg::REG_STAT: rdata_nxt = {16'h0, 1'b0, o_lamp, row_idx_r, 2'h0, state_r};
      cuc_pkg::REG_IRQ_ST: rdata_nxt = {27'h0, irq_st_r};
      cuc_pkg::REG_IRQ_MSK: rdata_nxt = {27'h0, irq_msk_r};
      default: rdata_nxt = 32'h0;
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0;
    end else if ((i_avs_read || i_avs_write) && o_avs_waitrequest) begin
      o_avs_waitrequest <= 1'b0;
      o_avs_readdata <= i_avs_read ? rdata_nxt : 32'h0;
    end else begin
      o_avs_waitrequest <= 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ctrl_r <= cuc_pkg::CTRL_RST;
      irq_msk_r <= cuc_pkg::IRQ_MSK_RST;
    end else if (wr_do && i_avs_byteenable[0]) begin
      if (i_avs_address == cuc_pkg::REG_CTRL) begin
        ctrl_r <= i_avs_writedata[1:0];
      end
      if (i_avs_address == cuc_pkg::REG_IRQ_MSK) begin
        irq_msk_r <= i_avs_writedata[4:0];
      end
    end
  end

  always_comb begin
    irq_ev = 5'h0;
    irq_ev[cuc_pkg::IRQ_CYC_END] = cyc_end;
    irq_ev[cuc_pkg::IRQ_B_STOP] = b_ev;
    irq_ev[cuc_pkg::IRQ_A_STOP] = i_mech.overheat & ~oh_d_r;
    irq_ev[cuc_pkg::IRQ_STOP] = stop_cond & ~o_lamp.stop;
    irq_ev[cuc_pkg::IRQ_JAM] = i_mech.jam & ~o_lamp.jam;
    irq_clr = (wr_do && i_avs_byteenable[0] && i_avs_address == cuc_pkg::REG_IRQ_ST) ? i_avs_writedata[4:0] : 5'h0;
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      irq_st_r <= 5'h0;
      o_irq <= 1'b0;
    end else begin
      irq_st_r <= irq_ev | (irq_st_r & ~irq_clr);
      o_irq <= |(irq_st_r & irq_msk_r);
    end
  end

  // Assertions
  property p_jam_stop;
    @(posedge i_clk_sys) disable iff (i_rst) i_mech.jam |=> !o_drive && !o_volt_en && o_lamp.jam;
  endproperty
  a_jam_stop: assert property (p_jam_stop) else $error("jam did not stop the unit");
  property p_overheat;
    @(posedge i_clk_sys) disable iff (i_rst) $rose(i_mech.overheat) |=> o_stop_a && o_lamp.overheat;
  endproperty
  a_overheat: assert property (p_overheat) else $error("overheat stop missing");
  property p_bstop_held;
    @(posedge i_clk_sys) disable iff (i_rst) o_stop_b && !i_host_ack |=> o_stop_b;
  endproperty
  a_bstop_held: assert property (p_bstop_held) else $error("B stop dropped before ack");
  property p_finish_cycle;
    @(posedge i_clk_sys) disable iff (i_rst)
      state_r == cuc_pkg::ST_RUN && !cyc_end && !i_mech.jam |=> state_r == cuc_pkg::ST_RUN && o_drive;
  endproperty
  a_finish_cycle: assert property (p_finish_cycle) else $error("halted mid cycle");
  property p_stop_lamp;
    @(posedge i_clk_sys) disable iff (i_rst) (i_panel.stop_btn || i_mech.rd_stk_full) |=> o_lamp.stop;
  endproperty
  a_stop_lamp: assert property (p_stop_lamp) else $error("stop lamp not lit");
  property p_stop_halts;
    @(posedge i_clk_sys) disable iff (i_rst) cyc_end && i_panel.standby |=> state_r != cuc_pkg::ST_RUN;
  endproperty
  a_stop_halts: assert property (p_stop_halts) else $error("standby did not halt");
  property p_noinfo;
    @(posedge i_clk_sys) disable iff (i_rst) noinfo_ev |=> o_lamp.no_info && o_stop_b && b_halt_r;
  endproperty
  a_noinfo: assert property (p_noinfo) else $error("no-information fault missing");
  property p_noreader;
    @(posedge i_clk_sys) disable iff (i_rst) nord_ev |=> o_lamp.no_rd_card ##1 o_stop_b || $past(i_host_ack);
  endproperty
  a_noreader: assert property (p_noreader) else $error("no reader card fault missing");
  property p_supply;
    @(posedge i_clk_sys) disable iff (i_rst) !i_mech.motor_ok |=> o_lamp.supply_loss_fault;
  endproperty
  a_supply: assert property (p_supply) else $error("supply lamp not lit");
  property p_hold_start;
    @(posedge i_clk_sys) disable iff (i_rst)
      cyc_end && i_panel.start && !stop_cond && !b_halt_r |=> state_r == cuc_pkg::ST_RUN && cyc_r == 32'h0;
  endproperty
  a_hold_start: assert property (p_hold_start) else $error("held start did not continue");
  property p_clear_bypass;
    @(posedge i_clk_sys) disable iff (i_rst)
      i_panel.clear && i_panel.start && !i_mech.rd_stk_full && !i_mech.wr_stk_full && !i_panel.stop_btn
      && !i_panel.standby && !i_mech.jam && !ctrl_r[0] |-> !stop_cond;
  endproperty
  a_clear_bypass: assert property (p_clear_bypass) else $error("clear did not bypass hopper stop");
  property p_single_press;
    @(posedge i_clk_sys) disable iff (i_rst) cyc_start |=> !man_pend_r;
  endproperty
  a_single_press: assert property (p_single_press) else $error("start press queued a second cycle");
  property p_jam_hold;
    @(posedge i_clk_sys) disable iff (i_rst)
      state_r == cuc_pkg::ST_JAM |=> state_r == cuc_pkg::ST_JAM && !o_volt_en && !o_drive;
  endproperty
  a_jam_hold: assert property (p_jam_hold) else $error("unit left the jam stop");
  c_run: cover property (@(posedge i_clk_sys) disable iff (i_rst) cyc_end ##1 state_r == cuc_pkg::ST_RUN);
  c_noinfo: cover property (@(posedge i_clk_sys) disable iff (i_rst) noinfo_ev);
  c_jam: cover property (@(posedge i_clk_sys) disable iff (i_rst) $rose(o_lamp.jam));
endmodule
`default_nettype wire

// >>> cuc_host_model.sv
// Host model: function selections, per-row transfer groups, stop acknowledges.
// Assumes the card unit runs the shortened cycle counts given as parameters.
`timescale 1ns/1ps
`default_nettype none
module cuc_host_model #(
  parameter int P_FIRST = 150,
  parameter int P_DL = 5,
  parameter int P_PER = 20
) (
  // Clock, reset and bench commands
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_go,
  input wire cuc_pkg::cuc_fsel_t i_fsel,
  input wire logic i_omit,
  input wire logic [35:0] i_data,
  // Card unit side
  input wire logic i_drive,
  input wire logic i_stop,
  output cuc_pkg::cuc_host_req_t o_host,
  output logic o_ack
);
  cuc_pkg::cuc_fsel_t sel_r;
  logic drv_r;
  int cnt_r, ack_r, ph, sl;
  assign ph = cnt_r - (P_FIRST - P_DL);
  assign sl = ph % P_PER;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_host <= '0;
      sel_r <= '0;
      {drv_r, cnt_r} <= '0;
    end else begin
      o_host <= '0;
      o_host.out_data <= i_data;
      drv_r <= i_drive;
      cnt_r <= i_drive ? cnt_r + 1 : 0;
      // Selection is dropped at cycle end so manual cycles see no transfers
      if (drv_r && !i_drive) sel_r <= '0;
      if (i_go) begin
        o_host.fsel_v <= 1'b1;
        o_host.fsel <= i_fsel;
        sel_r <= i_fsel;
      end
      // Three writes then three reads, right after each of the twelve row points
      if (i_drive && !i_omit && ph >= 0 && ph < 12 * P_PER && sl >= 1 && sl <= 6) begin
        o_host.out_v <= sl <= 3 && sel_r.punch;
        o_host.in_v <= sl > 3 && sel_r.read;
      end
    end
  end
  // Acknowledge late so each stop can be seen before it drops
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ack_r <= 0;
      o_ack <= 1'b0;
    end else begin
      ack_r <= i_stop ? ack_r + 1 : 0;
      o_ack <= ack_r % 8 == 7;
    end
  end
endmodule
`default_nettype wire

// >>> cuc_pkg.sv
// Shared constants and carrier types for the card unit cycle and fault control.
// Assumes a 100 MHz system clock; all times are turned into cycle counts here.
package cuc_pkg;
  // Timing, in microseconds as specified, and in 10 ns clock cycles
  localparam int unsigned CYC_PER_US = 100;
  localparam int unsigned FIRST_WIN_US = 140500;
  localparam int unsigned ROW_DL_US = 1500;
  localparam int unsigned ROW_PER_US = 12000;
  localparam int unsigned CARD_CYC_US = 300000;
  localparam int unsigned FIRST_WIN_CYC = FIRST_WIN_US * CYC_PER_US;
  localparam int unsigned ROW_DL_CYC = ROW_DL_US * CYC_PER_US;
  localparam int unsigned ROW_PER_CYC = ROW_PER_US * CYC_PER_US;
  localparam int unsigned CARD_CYC = CARD_CYC_US * CYC_PER_US;
  localparam logic [3:0] ROWS = 4'hc;
  localparam logic [1:0] GRP_XFERS = 2'h3;
  // Register byte offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_IRQ_ST = 4'h8;
  localparam logic [3:0] REG_IRQ_MSK = 4'hc;
  // Control fields and reset values
  localparam int unsigned CTRL_STANDBY_BIT = 0;
  localparam int unsigned CTRL_HOST_EN_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h2;
  localparam logic [4:0] IRQ_MSK_RST = 5'h00;
  // Interrupt status bit positions
  localparam int unsigned IRQ_CYC_END = 0;
  localparam int unsigned IRQ_B_STOP = 1;
  localparam int unsigned IRQ_A_STOP = 2;
  localparam int unsigned IRQ_STOP = 3;
  localparam int unsigned IRQ_JAM = 4;

  typedef struct packed {
    logic start;
    logic stop;
    logic free_run;
    logic pick_read;
    logic read;
    logic pick_punch;
    logic punch;
  } cuc_fsel_t;

  // function_select_instr, outbound_transfer_instr, inbound_transfer_instr
  typedef struct packed {
    logic fsel_v;
    cuc_fsel_t fsel;
    logic out_v;
    logic [35:0] out_data;
    logic in_v;
  } cuc_host_req_t;

  typedef struct packed {
    logic start;
    logic clear;
    logic stop_btn;
    logic standby;
    logic pick_read;
    logic pick_punch;
  } cuc_panel_t;

  typedef struct packed {
    logic rd_hop_empty;
    logic pn_hop_empty;
    logic rd_stk_full;
    logic wr_stk_full;
    logic rd_card;
    logic pn_card;
    logic jam;
    logic overheat;
    logic motor_ok;
    logic [35:0] sense;
  } cuc_mech_t;

  typedef struct packed {
    logic stop;
    logic overheat;
    logic no_info;
    logic supply_loss_fault;
    logic no_rd_card;
    logic no_pn_card;
    logic jam;
  } cuc_lamp_t;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_JAM} cuc_state_t;
endpackage

// >>> tb.sv
// Bench for the card unit: host model, panel, sensors and register bus traffic.
// Assumes the shortened cycle counts below; all expectations come from them.
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int CARD = 400, FIRST = 150, DL = 5, PER = 20;
  logic i_clk_sys, i_rst, avs_read, avs_write, host_ack, go, omit, in_q;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, o_avs_readdata;
  logic o_avs_waitrequest, o_irq, o_stop_a, o_stop_b, o_drive, o_volt_en, o_pick_read, o_pick_punch, o_punch_stb;
  logic [35:0] o_in_data, o_punch_data, hdata;
  cuc_pkg::cuc_host_req_t host;
  cuc_pkg::cuc_panel_t panel;
  cuc_pkg::cuc_mech_t mech;
  cuc_pkg::cuc_lamp_t o_lamp;
  cuc_pkg::cuc_fsel_t fsel;
  logic [35:0] pq[$], iq[$];
  logic [31:0] rq[$];
  int err_total, samples_checked, cyc, n;
  cuc_card_unit #(.P_CARD_CYC(CARD), .P_FIRST_WIN_CYC(FIRST), .P_ROW_PER_CYC(PER), .P_ROW_DL_CYC(DL)) uut (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_avs_address(avs_address), .i_avs_read(avs_read),
    .i_avs_write(avs_write), .i_avs_writedata(avs_writedata), .i_avs_byteenable(4'hf),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .o_irq(o_irq),
    .i_host(host), .i_host_ack(host_ack), .o_in_data(o_in_data), .o_stop_a(o_stop_a), .o_stop_b(o_stop_b),
    .i_panel(panel), .i_mech(mech), .o_lamp(o_lamp), .o_drive(o_drive), .o_volt_en(o_volt_en),
    .o_pick_read(o_pick_read), .o_pick_punch(o_pick_punch), .o_punch_data(o_punch_data),
    .o_punch_stb(o_punch_stb));
  cuc_host_model #(.P_FIRST(FIRST), .P_DL(DL), .P_PER(PER)) host_m (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_go(go), .i_fsel(fsel), .i_omit(omit), .i_data(hdata),
    .i_drive(o_drive), .i_stop(o_stop_a | o_stop_b), .o_host(host), .o_ack(host_ack));
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  task automatic wrap_up;
    $display("mismatches %0d of %0d checks", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      wrap_up();
    end
  end
  // Expected results are noted as they are launched and taken off at their answer
  always @(posedge i_clk_sys) begin
    hdata <= {4'($urandom), $urandom};
    mech.sense <= {4'($urandom), $urandom};
    in_q <= host.in_v;
    if (host.in_v) iq.push_back(mech.sense);
    if (host.out_v) pq.push_back(host.out_data);
    if (in_q && iq.size() > 0) chk("in_data", iq.pop_front(), o_in_data);
    if (o_punch_stb === 1'b1) chk("punch_data", pq.size() > 0 ? pq.pop_front() : ~o_punch_data, o_punch_data);
    if (avs_read && o_avs_waitrequest === 1'b0 && rq.size() > 0) chk("readdata", rq.pop_front(), o_avs_readdata);
  end
  task automatic tk(input int c);
    repeat (c) @(posedge i_clk_sys);
  endtask
  // Only the bench timeout ends a wait on the slave
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    tk(1);
    while (o_avs_waitrequest !== 1'b0) tk(1);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    tk(1);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  function automatic logic sig(input int w);
    return w == 0 ? o_drive : w == 1 ? o_stop_b : o_stop_a;
  endfunction
  task automatic wt(input int w, input logic v);
    int k;
    k = 0;
    while (sig(w) !== v && k < 2000) begin
      tk(1);
      k++;
    end
    if (k == 2000) chk("wait", v, ~v);
  endtask
  task automatic press;
    panel.start <= 1'b1;
    tk(2);
    panel.start <= 1'b0;
  endtask
  // Counts high cycles of one card cycle; start is held only until it begins
  task automatic len(input logic p, output int c);
    panel.start <= p;
    wt(0, 1);
    panel.start <= 1'b0;
    c = 0;
    while (o_drive === 1'b1 && c < 1000) begin
      tk(1);
      c++;
    end
  endtask
  task automatic hgo(input cuc_pkg::cuc_fsel_t f);
    fsel <= f;
    go <= 1'b1;
    tk(1);
    go <= 1'b0;
  endtask
  task automatic setc(input logic [4:0] v);
    {mech.rd_stk_full, mech.wr_stk_full, mech.rd_hop_empty, mech.pn_hop_empty, panel.standby} <= v;
  endtask
  initial begin
    void'($urandom(87));
    {i_rst, avs_read, avs_write, go, omit, in_q} = 6'h20;
    {avs_address, avs_writedata, hdata, fsel, panel} = '0;
    {err_total, samples_checked, cyc} = '0;
    // Cards in both stations, motor powered, nothing else active
    mech = {9'h019, 36'h0};
    tk(12);
    i_rst <= 1'b0;
    tk(1);
    rd(cuc_pkg::REG_CTRL, 32'h2);
    rd(cuc_pkg::REG_IRQ_MSK, 32'h0);
    rd(4'h2, 32'h0);
    chk("volt_en", 1, o_volt_en);
    bus(1'b1, cuc_pkg::REG_IRQ_ST, 32'h1f);
    len(1'b1, n);
    chk("cycle_len", 36'(CARD), 36'(n));
    tk(20);
    chk("single", 0, o_drive);
    rd(cuc_pkg::REG_IRQ_ST, 32'h1);
    {panel.pick_read, panel.pick_punch, panel.start} <= 3'h7;
    wt(0, 1);
    tk(2);
    chk("pick_read", 1, o_pick_read);
    chk("pick_punch", 1, o_pick_punch);
    tk(CARD);
    chk("held_run", 1, o_drive);
    panel.stop_btn <= 1'b1;
    tk(50);
    chk("finish_cycle", 1, o_drive);
    wt(0, 0);
    tk(30);
    chk("halted", 0, o_drive);
    chk("stop_lamp", 1, o_lamp.stop);
    panel.stop_btn <= 1'b0;
    wt(0, 1);
    {panel.pick_read, panel.pick_punch, panel.start} <= 3'h0;
    wt(0, 0);
    for (int i = 0; i < 5; i++) begin
      setc(5'h10 >> i);
      tk(3);
      chk("cond_stop", 1, o_lamp.stop);
      panel.start <= 1'b1;
      tk(20);
      chk("cond_block", 0, o_drive);
      panel.start <= 1'b0;
      tk(1);
      setc(5'h0);
      tk(3);
      chk("cond_clear", 0, o_lamp.stop);
      tk(5);
      wt(0, 0);
    end
    bus(1'b1, cuc_pkg::REG_IRQ_ST, 32'h1f);
    bus(1'b1, cuc_pkg::REG_IRQ_MSK, 32'h8);
    bus(1'b1, cuc_pkg::REG_CTRL, 32'h3);
    tk(3);
    chk("irq_on", 1, o_irq);
    chk("sw_standby", 1, o_lamp.stop);
    rd(cuc_pkg::REG_IRQ_ST, 32'h8);
    bus(1'b1, cuc_pkg::REG_IRQ_MSK, 32'h0);
    tk(3);
    chk("irq_masked", 0, o_irq);
    bus(1'b1, cuc_pkg::REG_IRQ_MSK, 32'h8);
    bus(1'b1, cuc_pkg::REG_IRQ_ST, 32'h8);
    tk(3);
    chk("irq_cleared", 0, o_irq);
    bus(1'b1, cuc_pkg::REG_CTRL, 32'h2);
    mech.rd_hop_empty <= 1'b1;
    {panel.clear, panel.start} <= 2'h3;
    wt(0, 1);
    tk(100);
    chk("clear_run", 1, o_drive);
    {panel.clear, panel.start} <= 2'h0;
    wt(0, 0);
    mech.rd_hop_empty <= 1'b0;
    hgo(7'h6f);
    wt(0, 1);
    wt(0, 0);
    chk("host_no_b", 0, o_stop_b);
    chk("host_info", 0, o_lamp.no_info);
    hgo(7'h40);
    len(1'b0, n);
    chk("start_only", 36'(CARD), 36'(n));
    omit <= 1'b1;
    hgo(7'h6c);
    wt(1, 1);
    chk("no_info", 1, o_lamp.no_info);
    chk("b_finish", 1, o_drive);
    wt(1, 0);
    chk("info_held", 1, o_lamp.no_info);
    wt(0, 0);
    hgo(7'h40);
    tk(20);
    chk("b_halt", 0, o_drive);
    press();
    tk(5);
    wt(0, 0);
    chk("info_clr", 0, o_lamp.no_info);
    for (int k = 0; k < 2; k++) begin
      {mech.rd_card, mech.pn_card} <= k ? 2'h2 : 2'h1;
      hgo(k ? 7'h63 : 7'h6c);
      wt(1, 1);
      chk("no_card", 1, k ? o_lamp.no_pn_card : o_lamp.no_rd_card);
      {mech.rd_card, mech.pn_card} <= 2'h3;
      wt(1, 0);
      wt(0, 0);
      press();
      tk(5);
      wt(0, 0);
    end
    omit <= 1'b0;
    press();
    mech.overheat <= 1'b1;
    wt(2, 1);
    chk("heat_lamp", 1, o_lamp.overheat);
    chk("heat_run", 1, o_drive);
    {mech.overheat, mech.motor_ok} <= 2'h0;
    tk(3);
    chk("supply_lamp", 1, o_lamp.supply_loss_fault);
    mech.motor_ok <= 1'b1;
    wt(0, 0);
    press();
    wt(0, 1);
    tk(10);
    mech.jam <= 1'b1;
    tk(2);
    chk("jam_drive", 0, o_drive);
    chk("jam_volt", 0, o_volt_en);
    chk("jam_lamp", 1, o_lamp.jam);
    chk("jam_stop", 1, o_lamp.stop);
    mech.jam <= 1'b0;
    press();
    tk(20);
    chk("jam_hold", 0, o_volt_en | o_drive);
    rd(cuc_pkg::REG_STAT, 32'h102);
    wrap_up();
  end
endmodule
`default_nettype wire
